// ---- bt_pkg.sv ----
// package for the basic 8-bit timer with rtc source
package bt_pkg;
   // ==========================================================
   // register map (byte addresses on the avalon bus)
   // ==========================================================
   localparam logic [7:0] BT_ADDR_MODE = 8'hb2;
   localparam logic [7:0] BT_ADDR_COUNT = 8'hb3;
   localparam logic [7:0] BT_ADDR_IRQ_STATUS = 8'hb8;
   localparam logic [7:0] BT_ADDR_IRQ_ENABLE = 8'hbc;
   localparam logic [7:0] BT_ADDR_IRQ_CLEAR = 8'hc0;
   // ==========================================================
   // field positions and reset values
   // ==========================================================
   localparam int BT_MODE_RUN_BIT = 7;
   localparam int BT_MODE_PRESCALE_LSB = 4;
   localparam int BT_MODE_RTC_BIT = 0;
   localparam logic [7:0] BT_MODE_RESET = 8'h00;
   localparam logic [7:0] BT_MODE_WMASK = 8'hf1;
   localparam logic [7:0] BT_COUNT_RESET = 8'h00;
   localparam int BT_IRQ_OVF_BIT = 0;
   localparam logic [7:0] BT_COUNT_FULL = 8'hff;
   localparam logic [7:0] BT_COUNT_ZERO = 8'h00;
   localparam logic [15:0] BT_VECTOR_ADDR = 16'h000b;
   // ==========================================================
   // timing: rtc tick is 32768 hz divided by 64
   // ==========================================================
   localparam int BT_RTC_DIV = 64;
   localparam int BT_PRESCALE_MAX = 256;
   localparam int BT_SYNC_STAGES = 3;

   typedef struct packed {
      logic run;
      logic [2:0] prescale;
      logic rtc_sel;
   } bt_mode_t;
endpackage : bt_pkg

// ---- bt_timer.sv ----
// basic 8-bit timer with rtc source, avalon-mm slave and interrupt
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/100ps
module bt_timer
   import bt_pkg::*;
#(
   parameter bit INTERNAL_RC_WITH_RTC = 1'b1
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cpu_tick_en,
   input wire logic rtc_osc_32k,
   input wire logic green_mode,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   output logic irq,
   output logic green_wake,
   output logic [15:0] irq_vector
);
   // ==========================================================
   // elaboration checks
   // ==========================================================
   localparam int RTC_DIV_W = $clog2(BT_RTC_DIV);
   localparam int PRESC_W = $clog2(BT_PRESCALE_MAX);

   // the rtc divider and the prescaler below are sized for these values
   // only; any other value would silently change the tick rates
   if (BT_SYNC_STAGES != 3)
   begin : g_bad_sync
      $error("rtc synchroniser is built for exactly three stages");
   end
   if (RTC_DIV_W != 6 || (1 << RTC_DIV_W) != BT_RTC_DIV)
   begin : g_bad_rtc_div
      $error("rtc divider must be 64 to keep the half second period");
   end
   if (PRESC_W != 8 || (1 << PRESC_W) != BT_PRESCALE_MAX)
   begin : g_bad_presc
      $error("prescaler must span 256 cpu ticks");
   end

   // ==========================================================
   // state
   // ==========================================================
   bt_mode_t mode_ff;
   logic [7:0] count_ff;
   logic ovf_flag_ff;
   logic irq_en_ff;
   logic [7:0] presc_ff;
   logic [5:0] rtc_div_ff;
   logic [BT_SYNC_STAGES-1:0] rtc_sync_ff;
   // bus phase is one-hot: idle takes a request, answer drops the wait
   typedef enum logic [1:0] {BT_BUS_IDLE = 2'b01, BT_BUS_ANSWER = 2'b10} bt_bus_state_t;
   bt_bus_state_t bus_state_ff;
   logic ack;
   logic rtc_level_ff;
   logic [31:0] rdata_ff;
   logic [1:0] resp_ff;
   logic wake_ff;
   logic wr_mode, wr_count, wr_clear, wr_ien, access, known;
   logic wr_en, sel_mode, sel_count, sel_status, sel_ien, sel_clear;
   logic rtc_active, rtc_rise, step, overflow, presc_hit;
   logic [7:0] presc_mask;
   logic [7:0] mode_rd;
   logic [7:0] rd_mux;

   // ==========================================================
   // avalon slave: one wait cycle, answer on the second edge
   // ==========================================================
   assign ack = (bus_state_ff == BT_BUS_ANSWER);
   // a request is taken in its first cycle and answered in the next
   assign access = (avs_read | avs_write) & ~ack;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;

   // address decode shared by the write strobes and the read mux
   always_comb
   begin
      sel_mode = 1'b0;
      sel_count = 1'b0;
      sel_status = 1'b0;
      sel_ien = 1'b0;
      sel_clear = 1'b0;
      if (avs_address == BT_ADDR_MODE)
         sel_mode = 1'b1;
      else if (avs_address == BT_ADDR_COUNT)
         sel_count = 1'b1;
      else if (avs_address == BT_ADDR_IRQ_STATUS)
         sel_status = 1'b1;
      else if (avs_address == BT_ADDR_IRQ_ENABLE)
         sel_ien = 1'b1;
      else if (avs_address == BT_ADDR_IRQ_CLEAR)
         sel_clear = 1'b1;
   end
   assign known = sel_mode | sel_count | sel_status | sel_ien | sel_clear;

   assign wr_en = access & avs_write & avs_byteenable[0];
   assign wr_mode = wr_en & sel_mode;
   assign wr_count = wr_en & sel_count;
   assign wr_ien = wr_en & sel_ien;
   assign wr_clear = wr_en & sel_clear & avs_writedata[BT_IRQ_OVF_BIT];
   assign mode_rd = {mode_ff.run, mode_ff.prescale, 3'h0, mode_ff.rtc_sel};

   // read mux: unmapped and write-only addresses read as zero
   always_comb
   begin
      rd_mux = 8'h00;
      if (sel_mode)
         rd_mux = mode_rd;
      else if (sel_count)
         rd_mux = count_ff;
      else if (sel_status)
         rd_mux = {7'h00, ovf_flag_ff};
      else if (sel_ien)
         rd_mux = {7'h00, irq_en_ff};
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         bus_state_ff <= BT_BUS_IDLE;
      else
      begin
         case (bus_state_ff)
            BT_BUS_IDLE:
               if (access)
                  bus_state_ff <= BT_BUS_ANSWER;
            BT_BUS_ANSWER:
               bus_state_ff <= BT_BUS_IDLE;
            default:
               bus_state_ff <= BT_BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_ff <= 32'h0000_0000;
         resp_ff <= 2'h0;
      end
      else if (access)
      begin
         resp_ff <= known ? 2'h0 : 2'h2;
         rdata_ff <= avs_read ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end
   assign avs_readdata = rdata_ff;
   assign avs_response = resp_ff;

   // ==========================================================
   // mode and interrupt enable registers
   // ==========================================================
   // bits 3 to 1 of the mode register are not stored and read as zero;
   // the source bit only sticks when the rtc build option is present
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         mode_ff <= bt_mode_t'(5'h00);
      else if (wr_mode)
      begin
         mode_ff.run <= avs_writedata[BT_MODE_RUN_BIT];
         mode_ff.prescale <= avs_writedata[BT_MODE_PRESCALE_LSB +: 3];
         mode_ff.rtc_sel <= avs_writedata[BT_MODE_RTC_BIT] & INTERNAL_RC_WITH_RTC;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         irq_en_ff <= 1'b0;
      else if (wr_ien)
         irq_en_ff <= avs_writedata[BT_IRQ_OVF_BIT];
   end

   // ==========================================================
   // tick sources
   // ==========================================================
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rtc_sync_ff <= '0;
      else
         rtc_sync_ff <= {rtc_sync_ff[BT_SYNC_STAGES-2:0], rtc_osc_32k};
   end
   // the pin level is taken over only once stages two and three agree,
   // so a metastable first stage never reaches the edge detector
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rtc_level_ff <= 1'b0;
      else if (rtc_sync_ff[1] == rtc_sync_ff[2])
         rtc_level_ff <= rtc_sync_ff[2];
   end
   // level resets low, the idle state of the oscillator input, so no
   // false rise follows reset
   assign rtc_rise = (rtc_sync_ff[1] == rtc_sync_ff[2]) & rtc_sync_ff[2] & ~rtc_level_ff;

   // without the rc-with-rtc build option the rtc path does not exist
   if (INTERNAL_RC_WITH_RTC)
   begin : g_rtc_on
      assign rtc_active = mode_ff.rtc_sel;
   end
   else
   begin : g_rtc_off
      assign rtc_active = 1'b0;
   end

   // ==========================================================
   // rtc divider
   // ==========================================================

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rtc_div_ff <= 6'h00;
      else if (!mode_ff.run || !rtc_active)
         rtc_div_ff <= 6'h00;
      else if (rtc_rise)
         rtc_div_ff <= rtc_div_ff + 6'h01;
   end

   // ==========================================================
   // prescaler
   // ==========================================================
   // code 0 -> /256 ... code 7 -> /2
   always_comb
   begin
      case (mode_ff.prescale)
         3'h0: presc_mask = 8'hff;
         3'h1: presc_mask = 8'h7f;
         3'h2: presc_mask = 8'h3f;
         3'h3: presc_mask = 8'h1f;
         3'h4: presc_mask = 8'h0f;
         3'h5: presc_mask = 8'h07;
         3'h6: presc_mask = 8'h03;
         3'h7: presc_mask = 8'h01;
         default: presc_mask = 8'hff;
      endcase
   end
   assign presc_hit = cpu_tick_en && ((presc_ff & presc_mask) == presc_mask);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         presc_ff <= 8'h00;
      else if (!mode_ff.run || rtc_active)
         presc_ff <= 8'h00;
      else if (cpu_tick_en)
         presc_ff <= presc_ff + 8'h01;
   end

   // ==========================================================
   // tick select
   // ==========================================================
   // rtc ignores the prescale field entirely
   always_comb
   begin
      step = 1'b0;
      if (!mode_ff.run)
         step = 1'b0;
      else if (rtc_active)
         step = rtc_rise && (rtc_div_ff == 6'(BT_RTC_DIV - 1));
      else
         step = presc_hit;
   end
   // a count write wins over a step, so that step cannot wrap the count
   // and must not raise the flag either
   assign overflow = step && !wr_count && (count_ff == BT_COUNT_FULL);

   // ==========================================================
   // counter
   // ==========================================================
   // no reload buffer: software owns the start value of every period,
   // the counter simply rolls on from zero
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         count_ff <= BT_COUNT_RESET;
      else if (wr_count)
         count_ff <= avs_writedata[7:0];
      else if (step)
         count_ff <= count_ff + 8'h01;
   end

   // ==========================================================
   // overflow flag, interrupt and green wake
   // ==========================================================
   // the flag is sticky; an overflow in the cycle of a clear keeps it set
   // so that no period is lost
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         ovf_flag_ff <= 1'b0;
      else if (overflow)
         ovf_flag_ff <= 1'b1;
      else if (wr_clear)
         ovf_flag_ff <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         wake_ff <= 1'b0;
      else
         wake_ff <= overflow & green_mode;
   end

   // wake is a single pulse; the system logic latches it as needed
   // level interrupt while an enabled flag is set
   assign irq = ovf_flag_ff & irq_en_ff;
   assign irq_vector = BT_VECTOR_ADDR;
   assign green_wake = wake_ff;
endmodule // bt_timer

// ---- bt_timer_checker.sv ----
// port checker for the basic timer
`timescale 1ns/100ps
module bt_timer_checker
   import bt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic green_mode,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   input wire logic irq,
   input wire logic green_wake,
   input wire logic [15:0] irq_vector
);
   // ==========================================================
   // bus and flag properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_rd(a);
      avs_read && !avs_waitrequest && avs_address == a;
   endsequence
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   // only a clear or enable write may drop the interrupt
   property p_sticky;
      irq && !(avs_write && (avs_address == BT_ADDR_IRQ_CLEAR ||
         avs_address == BT_ADDR_IRQ_ENABLE)) |=> irq;
   endproperty
   a_one_wait: assert property (s_req |=> !avs_waitrequest)
      else $error("request not answered after one wait");
   a_vector_fixed: assert property (irq_vector == BT_VECTOR_ADDR)
      else $error("vector changed");
   a_wake_green: assert property (green_wake |-> $past(green_mode))
      else $error("wake outside green mode");
   a_wake_pulse: assert property (green_wake |=> !green_wake)
      else $error("wake longer than one cycle");
   a_flag_sticky: assert property (p_sticky)
      else $error("interrupt dropped without software");
   a_mode_zeros: assert property (s_rd(BT_ADDR_MODE) |-> avs_readdata[3:1] == 3'h0)
      else $error("unused mode bits read nonzero");
   a_bad_addr: assert property (s_rd(8'hc4) |-> avs_response == 2'h2)
      else $error("unmapped read not refused");
   a_count_ok: assert property (s_rd(BT_ADDR_COUNT) |-> avs_readdata[31:8] == 24'h0)
      else $error("count read upper bits nonzero");
endmodule // bt_timer_checker
bind bt_timer bt_timer_checker u_chk (.clk_sys, .rst_n, .green_mode, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .avs_response, .irq, .green_wake, .irq_vector);

// ---- bt_timer_test.sv ----
// self-checking bench for the basic timer
`timescale 1ns/100ps
module bt_timer_test
   import bt_pkg::*;
;
   logic clk_sys = 1'b0, rst_n = 1'b0, rtc = 1'b0, green = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_rq, irq, wake;
   logic [15:0] lfsr = 16'hfa24;
   logic [7:0] expq[$];
   int mismatches = 0, n_checks = 0, wakes = 0;
   bt_timer DUT (.clk_sys, .rst_n, .cpu_tick_en(1'b1), .rtc_osc_32k(rtc), .green_mode(green),
      .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wait_rq),
      .avs_response(), .irq, .green_wake(wake), .irq_vector());
   initial forever #50 clk_sys = ~clk_sys;
   // slow oscillator: one rise every four clocks
   initial forever
   begin
      repeat (2) @(posedge clk_sys);
      rtc <= ~rtc;
   end
   // ==========================================================
   // tasks
   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic period(input int lo, input int hi);
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 600)
      begin
         @(negedge clk_sys);
         k++;
      end
      n_checks++;
      if (k < lo || k > hi)
      begin
         mismatches++;
         $display("mismatch at %0t: overflow after %0d cycles", $time, k);
      end
   endtask
   task automatic summarize();
      if (mismatches == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [7:0] e);
      @(posedge clk_sys);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      if (!w)
         expq.push_back(e);
      do @(posedge clk_sys); while (wait_rq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // ==========================================================
   // monitor and sequence
   always @(posedge clk_sys)
   begin
      if (wake === 1'b1)
         wakes++;
      if (rd === 1'b1 && wait_rq === 1'b0 && expq.size() > 0)
         cmp(rdata, {24'h0, expq.pop_front()});
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      bus(1'b0, BT_ADDR_MODE, 8'h00, BT_MODE_RESET);
      bus(1'b0, BT_ADDR_COUNT, 8'h00, BT_COUNT_RESET);
      bus(1'b0, 8'hc4, 8'h00, 8'h00);
      bus(1'b1, BT_ADDR_MODE, 8'h7e, 8'h00);
      bus(1'b0, BT_ADDR_MODE, 8'h00, 8'h70);
      repeat (4)
      begin
         lfsr = lfsr_step(lfsr);
         bus(1'b1, BT_ADDR_COUNT, lfsr[7:0], 8'h00);
         repeat (8) @(posedge clk_sys);
         bus(1'b0, BT_ADDR_COUNT, 8'h00, lfsr[7:0]);
      end
      bus(1'b1, BT_ADDR_IRQ_ENABLE, 8'h01, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         green <= (c == 3);
         bus(1'b1, BT_ADDR_MODE, 8'h00, 8'h00);
         bus(1'b1, BT_ADDR_COUNT, 8'hff, 8'h00);
         bus(1'b1, BT_ADDR_IRQ_CLEAR, 8'h01, 8'h00);
         bus(1'b0, BT_ADDR_IRQ_STATUS, 8'h00, 8'h00);
         bus(1'b1, BT_ADDR_MODE, {1'b0, 3'(c), 4'h0}, 8'h00);
         bus(1'b1, BT_ADDR_MODE, {1'b1, 3'(c), 4'h0}, 8'h00);
         period((256 >> c) - 2, (256 >> c) + 1);
         bus(1'b0, BT_ADDR_IRQ_STATUS, 8'h00, 8'h01);
         if (c == 0)
            bus(1'b0, BT_ADDR_COUNT, 8'h00, 8'h00);
      end
      bus(1'b1, BT_ADDR_MODE, 8'h00, 8'h00);
      bus(1'b1, BT_ADDR_MODE, 8'h80, 8'h00);
      bus(1'b1, BT_ADDR_COUNT, 8'h40, 8'h00);
      bus(1'b0, BT_ADDR_COUNT, 8'h00, 8'h40);
      bus(1'b1, BT_ADDR_IRQ_ENABLE, 8'h00, 8'h00);
      cmp(irq, 1'b0);
      bus(1'b1, BT_ADDR_IRQ_ENABLE, 8'h01, 8'h00);
      cmp(irq, 1'b1);
      bus(1'b1, BT_ADDR_IRQ_CLEAR, 8'h01, 8'h00);
      cmp(irq, 1'b0);
      bus(1'b1, BT_ADDR_COUNT, 8'hff, 8'h00);
      bus(1'b1, BT_ADDR_MODE, 8'h71, 8'h00);
      bus(1'b1, BT_ADDR_MODE, 8'hf1, 8'h00);
      period(245, 265);
      cmp(wakes, 1);
      summarize();
   end
   initial
   begin
      #1000000;
      mismatches++;
      summarize();
   end
endmodule // bt_timer_test
